// ### logic/cfgl_defines.vh
// register map, field positions, reset values and counts for the config loader
`ifndef CFGL_DEFINES_VH
`define CFGL_DEFINES_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CFGL_OFF_CTRL      8'h00
`define CFGL_OFF_STATE     8'h04
`define CFGL_OFF_DL_ADDR   8'h08
`define CFGL_OFF_DL_DATA   8'h0c
`define CFGL_OFF_RD_ADDR   8'h10
`define CFGL_OFF_RD_DATA   8'h14
`define CFGL_OFF_PASSWORD  8'h18
`define CFGL_OFF_KEY       8'h1c
`define CFGL_OFF_VERIFY    8'h20
`define CFGL_OFF_SLOT      8'h24
`define CFGL_OFF_IRQ_STAT  8'h28
`define CFGL_OFF_IRQ_EN    8'h2c
`define CFGL_OFF_IRQ_CLR   8'h30

// ----------------------------------------------------------------
// control register bits (write one to act)
// ----------------------------------------------------------------
`define CFGL_CTL_START     0
`define CFGL_CTL_STOP      1
`define CFGL_CTL_SIM_DONE  2
`define CFGL_CTL_DL_BEGIN  3
`define CFGL_CTL_DL_FINISH 4
`define CFGL_CTL_TO_FLASH  5
`define CFGL_CTL_PROTECT   6

// verify class field inside the read address register
`define CFGL_VFY_CLS_LO    16

// ----------------------------------------------------------------
// interrupt status bits
// ----------------------------------------------------------------
`define CFGL_IRQ_LOAD_DONE 0
`define CFGL_IRQ_DL_DONE   1
`define CFGL_IRQ_WEAR      2
`define CFGL_IRQ_DENIED    3
`define CFGL_IRQ_MISMATCH  4
`define CFGL_IRQ_COMM_ERR  5
`define CFGL_IRQ_WR_FAIL   6
`define CFGL_IRQ_W         7

// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define CFGL_RST_SLOT      8'h00
`define CFGL_RST_IRQ_EN    7'h00
`define CFGL_WEAR_LIMIT    16'd10000

`endif

// ### logic/cfgl_sync3.v
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module cfgl_sync3 #(
	parameter WIDTH = 2
) (
	// clock and reset
	input  wire             pclk,
	input  wire             presetn,
	// raw pin level and filtered level
	input  wire [WIDTH-1:0] pin_in,
	output reg  [WIDTH-1:0] level_out
);
	reg [WIDTH-1:0] s1_reg;	// first stage, read only by s2
	reg [WIDTH-1:0] s2_reg;	// second stage
	reg [WIDTH-1:0] s3_reg;	// third stage

	// ------------------------------------------------------------
	// shift chain and agreement filter
	// ------------------------------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s1_reg    <= {WIDTH{1'b0}};
			s2_reg    <= {WIDTH{1'b0}};
			s3_reg    <= {WIDTH{1'b0}};
			level_out <= {WIDTH{1'b0}};
		end
		else
		begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			// bits where two and three agree take the new level
			level_out <= (~(s2_reg ^ s3_reg) & s3_reg) |
				((s2_reg ^ s3_reg) & level_out);
		end
	end
endmodule // cfgl_sync3
`default_nettype wire

// ### logic/cfgl_wear.v
// flash write counter with an endurance limit and an over-limit error pulse
`timescale 1ns/10ps
`default_nettype none
`include "cfgl_defines.vh"
module cfgl_wear #(
	parameter [15:0] LIMIT = `CFGL_WEAR_LIMIT
) (
	// clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// one pulse per flash write
	input  wire        inc,
	// running count and error pulse
	output reg  [15:0] count,
	output reg         over_err
);
	// ------------------------------------------------------------
	// count, saturating, and flag each write past the limit
	// ------------------------------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			count    <= 16'h0000;
			over_err <= 1'b0;
		end
		else
		begin
			over_err <= 1'b0;
			if (inc)
			begin
				if (count != 16'hffff)
					count <= count + 16'h0001;
				// the write still goes through; only an error is raised
				if (count >= LIMIT)
					over_err <= 1'b1;
			end
		end
	end
endmodule // cfgl_wear
`default_nettype wire

// ### logic/cfgl_top.v
// run/stop control and configuration image loading for the user logic
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "cfgl_defines.vh"
// What this block does
// - power-up copies flash image into execution memory
// - logic stays stopped after power-up
// - simulation end leaves logic stopped
// - download while running halts, stores, then resumes
// - download while stopped keeps logic stopped
// - download targets execution memory or both
// - writes past flash limit flag error, still accepted
// - protected image reads need matching password
// - verify compares flash image, reports per class
// - entering stop clears counter timer counts
// - running flag high exactly while logic runs
// - last run or stop command wins, except a host run during a download
// - tool start overrides held host halt request
// - tool stop overrides held host run request
// - slot address mismatch ends access with error
module cfgl_top #(
	parameter AW = 6,	// execution and flash depth is 2**AW words
	parameter [15:0] WEAR_LIMIT = `CFGL_WEAR_LIMIT
) (
	// apb slave
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// host controller pins
	input  wire        logic_run_request,
	input  wire        logic_halt_request,
	input  wire [7:0]  host_slot_addr,
	output reg         logic_running_flag,
	// user logic side
	output reg         logic_enable,
	output reg         counter_clear,
	// interrupt
	output reg         irq
);
	// ------------------------------------------------------------
	// states
	// ------------------------------------------------------------
	localparam [1:0] ST_LOAD = 2'b00;	// power-up copy
	localparam [1:0] ST_IDLE = 2'b01;	// normal operation
	localparam [1:0] ST_DL   = 2'b10;	// download open

	// address match helper
	function hit;
		input [7:0] a;
		input [7:0] off;
		begin
			hit = (a == off);
		end
	endfunction

	// ------------------------------------------------------------
	// storage and state
	// ------------------------------------------------------------
	reg [31:0]   exec_mem  [0:(1<<AW)-1];	// execution memory
	reg [31:0]   flash_mem [0:(1<<AW)-1];	// non-volatile image
	reg [1:0]    state_reg;	// sequencer state
	reg [1:0]    state_next;
	reg          running_reg;	// user logic running
	reg          running_next;
	reg          resume_reg;	// restart after download
	reg          resume_next;
	reg          to_flash_reg;	// current download also hits flash
	reg          to_flash_next;
	reg          prot_pend_reg;	// protect bit for open download
	reg          prot_pend_next;
	reg          protect_reg;	// stored image is protected
	reg          protect_next;
	reg          unlocked_reg;	// matching key supplied
	reg          unlocked_next;
	reg [AW-1:0] load_idx_reg;	// power-up copy index
	reg [AW-1:0] dl_addr_reg;	// download word address
	reg [AW-1:0] rd_addr_reg;	// read and verify address
	reg [1:0]    vfy_cls_reg;	// verify class select
	reg [2:0]    vfy_mis_reg;	// per-class mismatch
	reg [31:0]   pw_reg;	// stored password
	reg [7:0]    slot_reg;	// tool-side slot address
	reg [6:0]    irq_stat_reg;	// sticky events
	reg [6:0]    irq_en_reg;	// interrupt enables
	reg [1:0]    host_prev_reg;	// previous synced host levels
	reg [6:0]    evt;	// events this cycle

	wire [1:0]   host_lvl;	// synced run/halt levels
	wire [15:0]  wear_count;	// flash writes so far
	wire         wear_err;	// write past the limit

	// ------------------------------------------------------------
	// bus phase decode
	// ------------------------------------------------------------
	wire acc      = psel & penable;
	wire done     = acc & pready;	// completing edge
	wire wr_done  = done & pwrite;
	wire rd_done  = done & ~pwrite;
	wire wr_ctrl  = wr_done & hit(paddr, `CFGL_OFF_CTRL);
	wire wr_dl    = wr_done & hit(paddr, `CFGL_OFF_DL_DATA);
	wire wr_vfy   = wr_done & hit(paddr, `CFGL_OFF_VERIFY);
	wire rd_data  = rd_done & hit(paddr, `CFGL_OFF_RD_DATA);
	wire locked   = protect_reg & ~unlocked_reg;
	wire [31:0] fl_word = flash_mem[rd_addr_reg];

	// tool and host commands
	wire tool_start = wr_ctrl & pwdata[`CFGL_CTL_START];
	wire tool_stop  = wr_ctrl & (pwdata[`CFGL_CTL_STOP] | pwdata[`CFGL_CTL_SIM_DONE]);
	wire dl_begin   = wr_ctrl & pwdata[`CFGL_CTL_DL_BEGIN];
	wire dl_finish  = wr_ctrl & pwdata[`CFGL_CTL_DL_FINISH];
	wire host_run   = host_lvl[0] & ~host_prev_reg[0];
	wire host_halt  = host_lvl[1] & ~host_prev_reg[1];
	wire start_evt  = tool_start | host_run;
	wire stop_evt   = tool_stop | host_halt;

	// ------------------------------------------------------------
	// children
	// ------------------------------------------------------------
	cfgl_sync3 #(
		.WIDTH     (2)
	) u_sync (
		.pclk      (pclk),
		.presetn   (presetn),
		.pin_in    ({logic_halt_request, logic_run_request}),
		.level_out (host_lvl)
	);

	cfgl_wear #(
		.LIMIT     (WEAR_LIMIT)
	) u_wear (
		.pclk      (pclk),
		.presetn   (presetn),
		.inc       ((state_reg == ST_DL) & dl_finish & to_flash_reg),
		.count     (wear_count),
		.over_err  (wear_err)
	);

	// ------------------------------------------------------------
	// sequencer and run/stop decision
	// ------------------------------------------------------------
	always @*
	begin
		state_next     = state_reg;
		running_next   = running_reg;
		resume_next    = resume_reg;
		to_flash_next  = to_flash_reg;
		prot_pend_next = prot_pend_reg;
		protect_next   = protect_reg;
		unlocked_next  = unlocked_reg;
		evt            = 7'h00;
		evt[`CFGL_IRQ_WEAR] = wear_err;
		case (state_reg)
			ST_LOAD:
			begin
				// logic held stopped while the image is copied
				running_next = 1'b0;
				if (load_idx_reg == {AW{1'b1}})
				begin
					state_next = ST_IDLE;
					evt[`CFGL_IRQ_LOAD_DONE] = 1'b1;
				end
			end
			ST_IDLE:
			begin
				// stop wins a same-cycle tie, otherwise last command counts
				if (stop_evt)
					running_next = 1'b0;
				else if (start_evt)
					running_next = 1'b1;
				if (dl_begin)
				begin
					if (slot_reg != host_slot_addr)
						evt[`CFGL_IRQ_COMM_ERR] = 1'b1;
					else
					begin
						state_next     = ST_DL;
						resume_next    = running_reg;
						running_next   = 1'b0;
						to_flash_next  = pwdata[`CFGL_CTL_TO_FLASH];
						prot_pend_next = pwdata[`CFGL_CTL_PROTECT];
					end
				end
			end
			ST_DL:
			begin
				running_next = 1'b0;
				// tool commands and host halt during the download only change what follows it; host run flags a write failure
				if (stop_evt)
					resume_next = 1'b0;
				else if (tool_start)
					resume_next = 1'b1;
				if (host_run)
					evt[`CFGL_IRQ_WR_FAIL] = 1'b1;
				if (dl_finish)
				begin
					state_next   = ST_IDLE;
					running_next = resume_reg & ~stop_evt;
					evt[`CFGL_IRQ_DL_DONE] = 1'b1;
					if (to_flash_reg)
					begin
						protect_next  = prot_pend_reg;
						unlocked_next = 1'b0;
					end
				end
			end
			default:
			begin
				state_next   = ST_IDLE;
				running_next = 1'b0;
			end
		endcase
		// key check for protected reads
		if (wr_done & hit(paddr, `CFGL_OFF_KEY))
			unlocked_next = (pwdata == pw_reg);
		if (rd_data & locked)
			evt[`CFGL_IRQ_DENIED] = 1'b1;
		if (wr_vfy & (pwdata != fl_word))
			evt[`CFGL_IRQ_MISMATCH] = 1'b1;
	end

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg          <= ST_LOAD;
			running_reg        <= 1'b0;
			resume_reg         <= 1'b0;
			to_flash_reg       <= 1'b0;
			prot_pend_reg      <= 1'b0;
			protect_reg        <= 1'b0;
			unlocked_reg       <= 1'b0;
			host_prev_reg      <= 2'b00;
			logic_running_flag <= 1'b0;
			logic_enable       <= 1'b0;
			counter_clear      <= 1'b0;
		end
		else
		begin
			state_reg          <= state_next;
			running_reg        <= running_next;
			resume_reg         <= resume_next;
			to_flash_reg       <= to_flash_next;
			prot_pend_reg      <= prot_pend_next;
			protect_reg        <= protect_next;
			unlocked_reg       <= unlocked_next;
			host_prev_reg      <= host_lvl;
			logic_running_flag <= running_next;
			logic_enable       <= running_next;
			// one pulse whenever the logic falls into stop
			counter_clear      <= running_reg & ~running_next;
		end
	end

	// ------------------------------------------------------------
	// address counters and software settings
	// ------------------------------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			load_idx_reg <= {AW{1'b0}};
			dl_addr_reg  <= {AW{1'b0}};
			rd_addr_reg  <= {AW{1'b0}};
			vfy_cls_reg  <= 2'b00;
			vfy_mis_reg  <= 3'b000;
			pw_reg       <= 32'h00000000;
			slot_reg     <= `CFGL_RST_SLOT;
			irq_en_reg   <= `CFGL_RST_IRQ_EN;
		end
		else
		begin
			if (state_reg == ST_LOAD)
				load_idx_reg <= load_idx_reg + 1'b1;
			// download address, auto-advancing per data word
			if (wr_done & hit(paddr, `CFGL_OFF_DL_ADDR))
				dl_addr_reg <= pwdata[AW-1:0];
			else if (wr_dl & (state_reg == ST_DL))
				dl_addr_reg <= dl_addr_reg + 1'b1;
			// read/verify address also selects class and clears results
			if (wr_done & hit(paddr, `CFGL_OFF_RD_ADDR))
			begin
				rd_addr_reg <= pwdata[AW-1:0];
				vfy_cls_reg <= pwdata[`CFGL_VFY_CLS_LO+1:`CFGL_VFY_CLS_LO];
				vfy_mis_reg <= 3'b000;
			end
			else if (rd_data | wr_vfy)
				rd_addr_reg <= rd_addr_reg + 1'b1;
			// connections, settings and user addresses each tracked
			if (wr_vfy & (pwdata != fl_word) & (vfy_cls_reg != 2'b11))
				vfy_mis_reg[vfy_cls_reg] <= 1'b1;
			if (wr_done & hit(paddr, `CFGL_OFF_PASSWORD))
				pw_reg <= pwdata;
			if (wr_done & hit(paddr, `CFGL_OFF_SLOT))
				slot_reg <= pwdata[7:0];
			if (wr_done & hit(paddr, `CFGL_OFF_IRQ_EN))
				irq_en_reg <= pwdata[`CFGL_IRQ_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// image memories, no reset
	// ------------------------------------------------------------
	always @(posedge pclk)
	begin
		if (state_reg == ST_LOAD)
			exec_mem[load_idx_reg] <= flash_mem[load_idx_reg];
		else if (wr_dl & (state_reg == ST_DL))
		begin
			exec_mem[dl_addr_reg] <= pwdata;
			if (to_flash_reg)
				flash_mem[dl_addr_reg] <= pwdata;
		end
	end

	// ------------------------------------------------------------
	// interrupt status: set beats clear
	// ------------------------------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_stat_reg <= 7'h00;
			irq          <= 1'b0;
		end
		else
		begin
			if (wr_done & hit(paddr, `CFGL_OFF_IRQ_CLR))
				irq_stat_reg <= (irq_stat_reg & ~pwdata[`CFGL_IRQ_W-1:0]) | evt;
			else
				irq_stat_reg <= irq_stat_reg | evt;
			irq <= |(irq_stat_reg & irq_en_reg);
		end
	end

	// ------------------------------------------------------------
	// apb answer: one wait state, data latched in first access cycle
	// ------------------------------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end
		else
		begin
			pready  <= acc & ~pready;
			pslverr <= 1'b0;
			if (acc & ~pready)
			begin
				prdata <= 32'h00000000;
				case (paddr)
					`CFGL_OFF_CTRL:
						prdata <= {25'h0, protect_reg, to_flash_reg, 5'h00};
					`CFGL_OFF_STATE:
						prdata <= {wear_count, 9'h000, vfy_mis_reg, protect_reg,
							state_reg == ST_DL, state_reg == ST_LOAD, running_reg};
					`CFGL_OFF_DL_ADDR:
						prdata[AW-1:0] <= dl_addr_reg;
					`CFGL_OFF_RD_ADDR:
						prdata <= {14'h0, vfy_cls_reg, {(16-AW){1'b0}}, rd_addr_reg};
					`CFGL_OFF_RD_DATA:
						prdata <= locked ? 32'h00000000 : fl_word;
					`CFGL_OFF_SLOT:
						prdata[7:0] <= slot_reg;
					`CFGL_OFF_IRQ_STAT:
						prdata[`CFGL_IRQ_W-1:0] <= irq_stat_reg;
					`CFGL_OFF_IRQ_EN:
						prdata[`CFGL_IRQ_W-1:0] <= irq_en_reg;
					`CFGL_OFF_DL_DATA, `CFGL_OFF_PASSWORD, `CFGL_OFF_KEY,
					`CFGL_OFF_VERIFY, `CFGL_OFF_IRQ_CLR:
						prdata <= 32'h00000000;	// write-only
					default:
						pslverr <= 1'b1;	// unmapped
				endcase
				// refused tool download start answers with an error
				if (pwrite & hit(paddr, `CFGL_OFF_CTRL) & pwdata[`CFGL_CTL_DL_BEGIN] &
					(state_reg == ST_IDLE) & (slot_reg != host_slot_addr))
					pslverr <= 1'b1;
			end
		end
	end
endmodule // cfgl_top
`default_nettype wire

// ### tb/cfgl_top_props.sv
// checker for the config loader ports, bound to cfgl_top
`timescale 1ns/10ps
`default_nettype none
`include "cfgl_defines.vh"
module cfgl_top_props (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// run state
	input wire logic        logic_running_flag,
	input wire logic        logic_enable,
	input wire logic        counter_clear
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ------------------------------------------------------
	// transfer steps
	// ------------------------------------------------------
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence access_s;
		psel && penable;
	endsequence
	// completed control write that carries stop or sim end
	sequence stop_wr_s;
		access_s ##0 pready && pwrite && paddr == `CFGL_OFF_CTRL
			&& (pwdata[`CFGL_CTL_STOP] || pwdata[`CFGL_CTL_SIM_DONE]);
	endsequence
	// ------------------------------------------------------
	// assertions
	// ------------------------------------------------------
	answer_time_a: assert property (setup_s ##1 access_s |=> pready)
		else $error("pready late after access");
	pready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	pready_access_a: assert property (pready |-> psel && penable)
		else $error("pready outside access phase");
	slverr_pready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	flag_enable_a: assert property (logic_enable == logic_running_flag)
		else $error("enable and flag differ");
	stop_clear_a: assert property ($fell(logic_running_flag) |-> ##[0:1] counter_clear)
		else $error("no counter clear on stop");
	reset_stop_a: assert property ($rose(presetn) |-> !logic_running_flag [*8])
		else $error("logic runs after reset");
	tool_stop_a: assert property (stop_wr_s |-> ##[1:2] !logic_running_flag)
		else $error("tool stop ignored");
endmodule // cfgl_top_props
bind cfgl_top cfgl_top_props cfgl_top_props_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.pslverr(pslverr), .logic_running_flag(logic_running_flag),
	.logic_enable(logic_enable), .counter_clear(counter_clear));
`default_nettype wire

// ### tb/cfgl_host_model.sv
// host controller model driving the run and halt pins and slot address
`timescale 1ns/10ps
`default_nettype none
module cfgl_host_model (
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// wishes from the bench
	input  wire logic       want_run,
	input  wire logic       want_halt,
	input  wire logic       dl_busy,
	input  wire logic [7:0] slot_cfg,
	// pins toward the block
	output var  logic       logic_run_request,
	output var  logic       logic_halt_request,
	output var  logic [7:0] host_slot_addr
);
	// pins change just after an edge, like an output card
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			logic_run_request  <= 1'b0;
			logic_halt_request <= 1'b0;
			host_slot_addr     <= 8'h00;
		end
		else
		begin
			// run held off while the tool downloads
			logic_run_request  <= want_run & ~dl_busy;
			// halt clears counts, so a mere pause never uses it
			logic_halt_request <= want_halt;
			// slot number as set on the host side
			host_slot_addr     <= slot_cfg;
		end
	end
endmodule // cfgl_host_model
`default_nettype wire

// ### tb/cfgl_top_tb.sv
// self-checking bench for the config loader block
`timescale 1ns/10ps
`default_nettype none
`include "cfgl_defines.vh"
module cfgl_top_tb;
	// ------------------------------------------------------
	// signals
	// ------------------------------------------------------
	logic        pclk = 1'b0;                  // 250 MHz clock
	logic        presetn = 1'b0;               // reset, low at start
	logic        psel = 1'b0, penable = 1'b0;  // apb strobes
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready, pslverr;
	logic        want_run = 1'b0, want_halt = 1'b0, dl_busy = 1'b0;
	logic [7:0]  slot_cfg = 8'h00;             // host slot number
	logic        run_pin, halt_pin;
	logic [7:0]  slot_pin;
	logic        flag, enable, clr, irq;
	logic [31:0] rd = 32'h0;                   // last read data
	logic        err;                          // last pslverr
	int          bad_count = 0;
	int          samples_checked = 0;
	int          clr_seen = 0;                 // counter clear pulses
	always #2 pclk = ~pclk;
	// count clear pulses at each edge
	always @(posedge pclk)
		if (clr === 1'b1) clr_seen++;
	// ------------------------------------------------------
	// instances
	// ------------------------------------------------------
	cfgl_top #(.WEAR_LIMIT(16'd3)) cfgl_top_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.logic_run_request(run_pin), .logic_halt_request(halt_pin),
		.host_slot_addr(slot_pin), .logic_running_flag(flag),
		.logic_enable(enable), .counter_clear(clr), .irq(irq));
	cfgl_host_model cfgl_host_model_i (.pclk(pclk), .presetn(presetn),
		.want_run(want_run), .want_halt(want_halt), .dl_busy(dl_busy),
		.slot_cfg(slot_cfg), .logic_run_request(run_pin),
		.logic_halt_request(halt_pin), .host_slot_addr(slot_pin));
	// ------------------------------------------------------
	// tasks
	// ------------------------------------------------------
	// one apb transfer, held until pready is seen high
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// compare and count
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		samples_checked++;
		if (g !== e)
		begin
			bad_count++;
			$display("mismatch at %0t: %s got %h expected %h", $time, m, g, e);
		end
	endtask
	// read a register and compare the masked bits
	task automatic rchk(input logic [7:0] a, input logic [31:0] k, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd & k, e, "register read");
	endtask
	// wait a bounded time for the run flag, then compare
	task automatic wflag(input logic v);
		for (int i = 0; i < 16 && flag !== v; i++) @(posedge pclk);
		chk({31'h0, flag}, {31'h0, v}, "run flag");
	endtask
	// download one word; f carries flash and protect bits
	task automatic dl(input logic [31:0] f, input logic [31:0] w);
		dl_busy <= 1'b1;
		bus(1'b1, `CFGL_OFF_CTRL, f | 32'h08);
		bus(1'b1, `CFGL_OFF_DL_ADDR, 32'h0);
		chk({31'h0, flag}, 32'h0, "halt during download");
		bus(1'b1, `CFGL_OFF_DL_DATA, w);
		bus(1'b1, `CFGL_OFF_CTRL, f | 32'h10);
		dl_busy <= 1'b0;
	endtask
	// verdict and end of run
	task automatic complete_run;
		$display("checked %0d, mismatched %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ------------------------------------------------------
	// tests
	// ------------------------------------------------------
	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		chk({31'h0, flag}, 32'h0, "stopped after reset");
		for (int i = 0; i < 40 && rd[0] !== 1'b1; i++) bus(1'b0, `CFGL_OFF_IRQ_STAT, 32'h0);
		chk(rd & 32'h1, 32'h1, "load done");
		rchk(`CFGL_OFF_STATE, 32'h3, 32'h0);
		bus(1'b1, `CFGL_OFF_IRQ_EN, 32'h1);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h1, "irq on");
		bus(1'b1, `CFGL_OFF_IRQ_CLR, 32'h1);
		bus(1'b1, `CFGL_OFF_IRQ_EN, 32'h0);
		rchk(`CFGL_OFF_IRQ_EN, 32'h7f, 32'h0);
		chk({31'h0, irq}, 32'h0, "irq off");
		bus(1'b0, 8'h40, 32'h0);
		chk({31'h0, err}, 32'h1, "unmapped error");
		chk(rd, 32'h0, "unmapped data");
		$display("test load and irq done");
		// run from the tool, stop from both sources, tool commands over held host pins
		bus(1'b1, `CFGL_OFF_CTRL, 32'h1);
		wflag(1'b1);
		@(posedge pclk) want_halt <= 1'b1;
		wflag(1'b0);
		repeat (2) @(posedge pclk);
		chk(clr_seen, 32'h1, "clear on stop");
		bus(1'b1, `CFGL_OFF_CTRL, 32'h1);
		wflag(1'b1);
		@(posedge pclk) want_run <= 1'b1;
		repeat (12) @(posedge pclk);
		bus(1'b1, `CFGL_OFF_CTRL, 32'h2);
		wflag(1'b0);
		repeat (2) @(posedge pclk);
		chk(clr_seen, 32'h2, "clear on stop");
		@(posedge pclk) want_run <= 1'b0;
		want_halt <= 1'b0;
		$display("test run stop done");
		// downloads while running and while stopped
		bus(1'b1, `CFGL_OFF_CTRL, 32'h1);
		wflag(1'b1);
		dl(32'h20, 32'ha5a50001);
		wflag(1'b1);
		rchk(`CFGL_OFF_STATE, 32'hffff0000, 32'h00010000);
		bus(1'b1, `CFGL_OFF_CTRL, 32'h2);
		wflag(1'b0);
		dl(32'h0, 32'h5a5a0002);
		repeat (8) @(posedge pclk);
		chk({31'h0, flag}, 32'h0, "stays stopped");
		rchk(`CFGL_OFF_STATE, 32'hffff0000, 32'h00010000);
		bus(1'b1, `CFGL_OFF_RD_ADDR, 32'h0);
		rchk(`CFGL_OFF_RD_DATA, 32'hffffffff, 32'ha5a50001);
		$display("test download done");
		// verify: match, then one mismatch per class
		bus(1'b1, `CFGL_OFF_RD_ADDR, 32'h0);
		bus(1'b1, `CFGL_OFF_VERIFY, 32'ha5a50001);
		rchk(`CFGL_OFF_STATE, 32'h70, 32'h0);
		for (int c = 0; c < 3; c++)
		begin
			bus(1'b1, `CFGL_OFF_RD_ADDR, 32'(c) << 16);
			bus(1'b1, `CFGL_OFF_VERIFY, 32'h5a5afffe);
			rchk(`CFGL_OFF_STATE, 32'h70, 32'h10 << c);
		end
		$display("test verify done");
		// protected image, then wear limit
		bus(1'b1, `CFGL_OFF_PASSWORD, 32'h00001234);
		dl(32'h60, 32'hc3c30003);
		bus(1'b1, `CFGL_OFF_RD_ADDR, 32'h0);
		rchk(`CFGL_OFF_RD_DATA, 32'hffffffff, 32'h0);
		rchk(`CFGL_OFF_IRQ_STAT, 32'h8, 32'h8);
		bus(1'b1, `CFGL_OFF_KEY, 32'h00001235);
		bus(1'b1, `CFGL_OFF_RD_ADDR, 32'h0);
		rchk(`CFGL_OFF_RD_DATA, 32'hffffffff, 32'h0);
		bus(1'b1, `CFGL_OFF_KEY, 32'h00001234);
		bus(1'b1, `CFGL_OFF_RD_ADDR, 32'h0);
		rchk(`CFGL_OFF_RD_DATA, 32'hffffffff, 32'hc3c30003);
		dl(32'h20, 32'h11110004);
		rchk(`CFGL_OFF_IRQ_STAT, 32'h4, 32'h0);
		dl(32'h20, 32'h22220005);
		rchk(`CFGL_OFF_IRQ_STAT, 32'h4, 32'h4);
		rchk(`CFGL_OFF_STATE, 32'hffff0000, 32'h00040000);
		bus(1'b1, `CFGL_OFF_KEY, 32'h00001234);
		bus(1'b1, `CFGL_OFF_RD_ADDR, 32'h0);
		rchk(`CFGL_OFF_RD_DATA, 32'hffffffff, 32'h22220005);
		$display("test protect and wear done");
		// simulation end, slot mismatch, masked interrupt
		bus(1'b1, `CFGL_OFF_CTRL, 32'h1);
		wflag(1'b1);
		bus(1'b1, `CFGL_OFF_CTRL, 32'h4);
		wflag(1'b0);
		bus(1'b1, `CFGL_OFF_SLOT, 32'h5);
		rchk(`CFGL_OFF_SLOT, 32'hff, 32'h5);
		bus(1'b1, `CFGL_OFF_CTRL, 32'h8);
		chk({31'h0, err}, 32'h1, "slot refused");
		rchk(`CFGL_OFF_IRQ_STAT, 32'h20, 32'h20);
		@(posedge pclk) slot_cfg <= 8'h05;
		repeat (3) @(posedge pclk);
		bus(1'b1, `CFGL_OFF_CTRL, 32'h8);
		chk({31'h0, err}, 32'h0, "slot accepted");
		bus(1'b1, `CFGL_OFF_CTRL, 32'h10);
		chk({31'h0, irq}, 32'h0, "irq masked");
		bus(1'b1, `CFGL_OFF_IRQ_EN, 32'h2);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h1, "irq enabled");
		bus(1'b1, `CFGL_OFF_IRQ_CLR, 32'h2);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h0, "irq cleared");
		$display("test slot and irq done");
		complete_run();
	end
	// watchdog: the tests need about 500 cycles, allow 10000
	initial
	begin
		#40000;
		bad_count++;
		$display("mismatch at %0t: watchdog expired", $time);
		complete_run();
	end
endmodule // cfgl_top_tb
`default_nettype wire
